// ==== verilog/acb_pkg.sv ====
// Notes on behaviour
// - With edge select high the sample outputs change on the rising strobe edge, with it low on the falling one.
// - A mid-supply level on the edge-select pin puts the device into test mode.
// - The capture write enable is synchronised to the sample clock and driven onto its own output.
// - The data-ready strobe changes together with every change of the sample outputs made by a read; the reset pin zeroes the outputs and forces the strobe low.
// - Each sample appears on eight parallel bits, bit 0 least and bit 7 most significant.
// - The full flag is high while the buffer holds its selected number of entries.
// - The empty flag is high while the buffer holds no unread entry.
// - With the buffer enabled and auto-stop high, writing stops once the buffer is full.
// - With the buffer disabled the auto-stop input is ignored.
// - In test mode the auto-stop input serves as the output edge select.
// - A two-bit size select sets the buffer depth.
// - A two-bit multiply select sets the clock multiplier factor.
// - While write enable is high one sample byte is stored per sample clock edge.
// - While read enable is high one byte is read out per rising readout clock edge.
// - A high level on the reset pin flushes the buffer, zeroes the sample outputs and strobe and restores buffer enable;
//   the interrupt registers are not cleared, but the flush can set the empty status bit.
package acb_pkg;
	localparam int DATA_W = 8;
	localparam int DEPTH_MAX = 1024;
	localparam int PTR_W = 10;
	localparam int CNT_W = 11;
	localparam int SYNC_W = 11;
	localparam int IRQ_W = 3;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
	localparam int CTRL_BUF_EN = 0;
	localparam int CTRL_FLUSH = 1;
	localparam logic CTRL_BUF_EN_RST = 1'h1;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
	localparam int IRQ_FULL = 0;
	localparam int IRQ_EMPTY = 1;
	localparam int IRQ_OVER = 2;
	localparam int STAT_FULL = 0;
	localparam int STAT_EMPTY = 1;
	localparam int STAT_TEST = 2;
	localparam int STAT_WEN = 3;
	localparam int STAT_BUF_EN = 4;
	localparam int STAT_DEPTH = 8;
	localparam int STAT_PLL = 10;
	localparam int STAT_COUNT = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Depth select: 128 entries shifted left by the select value
	// ------------------------------------------------------------
	localparam logic [CNT_W-1:0] DEPTH_BASE = 11'h080;

	function automatic logic [CNT_W-1:0] acb_depth_of(input logic [1:0] sel);
		acb_depth_of = DEPTH_BASE << sel;
	endfunction : acb_depth_of
endpackage : acb_pkg

// ==== verilog/acb_fifo_if.sv ====
`timescale 1ns/1ps
interface acb_fifo_if;
	logic wr;
	logic pop;
	logic flush;
	logic [1:0] depth_sel;
	logic [acb_pkg::DATA_W-1:0] wr_data;
	logic [acb_pkg::DATA_W-1:0] rd_data;
	logic [acb_pkg::CNT_W-1:0] count;
	logic full;
	logic empty;

	modport ctrl (
		output wr, pop, flush, depth_sel, wr_data,
		input rd_data, count, full, empty
	);
	modport store (
		input wr, pop, flush, depth_sel, wr_data,
		output rd_data, count, full, empty
	);
endinterface : acb_fifo_if

// ==== verilog/acb_sync.sv ====
`timescale 1ns/1ps
module acb_sync #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule : acb_sync

// ==== verilog/acb_buf.sv ====
`timescale 1ns/1ps
module acb_buf #(
	parameter int DEPTH = 1024
) (
	input wire logic clock,
	input wire logic rstn,
	acb_fifo_if.store fi
);
	if (DEPTH != acb_pkg::DEPTH_MAX) begin : g_bad_depth
		$error("acb_buf: DEPTH must equal DEPTH_MAX");
	end

	logic [acb_pkg::DATA_W-1:0] mem [DEPTH];
	logic [acb_pkg::PTR_W-1:0] wp, rp, next_wp, next_rp;
	logic [acb_pkg::CNT_W-1:0] cnt, next_cnt, lim;

	// Shrinking the depth below the fill level just reads as full
	assign lim = acb_pkg::acb_depth_of(fi.depth_sel);
	assign fi.full = (cnt >= lim);
	assign fi.empty = (cnt == '0);
	assign fi.count = cnt;
	assign fi.rd_data = mem[rp];

	always_comb begin
		next_wp = wp;
		next_rp = rp;
		next_cnt = cnt;
		if (fi.flush) begin
			next_wp = '0;
			next_rp = '0;
			next_cnt = '0;
		end else begin
			if (fi.wr) begin
				next_wp = wp + 1'b1;
			end
			// Overwrite when full drops the oldest entry
			if ((fi.pop && !fi.empty) || (fi.wr && fi.full)) begin
				next_rp = rp + 1'b1;
			end
			if (fi.wr && !fi.full && !(fi.pop && !fi.empty)) begin
				next_cnt = cnt + 1'b1;
			end else if (!fi.wr && fi.pop && !fi.empty) begin
				next_cnt = cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
		end
	end

	always_ff @(posedge clock) begin
		if (fi.wr && !fi.flush) begin
			mem[wp] <= fi.wr_data;
		end
	end
endmodule : acb_buf

// ==== verilog/acb_top.sv ====
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module acb_top (
	input wire logic clock,
	input wire logic rstn,
	input wire logic reset_pin,
	input wire logic [7:0] sample_in,
	input wire logic write_enable,
	input wire logic read_enable,
	input wire logic read_clock,
	input wire logic output_edge_select_or_test,
	input wire logic test_level_sense,
	input wire logic auto_stop_write,
	input wire logic [1:0] buffer_depth_select,
	input wire logic [1:0] pll_factor_select,
	output logic [7:0] sample_out_bits,
	output logic data_ready_strobe,
	output logic buffer_full_flag,
	output logic buffer_empty_flag,
	output logic write_enable_synced_out,
	output logic [1:0] pll_factor,
	output logic test_mode,
	output logic irq,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [acb_pkg::SYNC_W-1:0] pins_s;
	logic rst_s, wen_s, ren_s, rclk_s, oedge_s, tlev_s, asw_s;
	logic [1:0] bsize_s, mult_s;

	acb_sync #(.W(acb_pkg::SYNC_W)) u_sync (
		.clock(clock),
		.rstn(rstn),
		.din({reset_pin, write_enable, read_enable, read_clock, output_edge_select_or_test,
			test_level_sense, auto_stop_write, buffer_depth_select, pll_factor_select}),
		.dout(pins_s)
	);
	assign {rst_s, wen_s, ren_s, rclk_s, oedge_s, tlev_s, asw_s, bsize_s, mult_s} = pins_s;
	assign write_enable_synced_out = wen_s;

	// ------------------------------------------------------------
	// Capture buffer
	// ------------------------------------------------------------
	acb_fifo_if fifo ();

	acb_buf #(.DEPTH(acb_pkg::DEPTH_MAX)) u_buf (
		.clock(clock),
		.rstn(rstn),
		.fi(fifo)
	);

	// ------------------------------------------------------------
	// Control and readout datapath
	// ------------------------------------------------------------
	logic buf_en, next_buf_en;
	logic flush, next_flush;
	logic rclk_q, next_rclk_q;
	logic [7:0] next_out;
	logic next_strobe;
	logic next_full_f, next_empty_f, next_test;
	logic [1:0] next_pll;
	logic test_reg;
	logic eff_edge, auto_stop, rrise, load, over_ev;
	logic [acb_pkg::IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, irq_ev;
	logic next_irq;
	logic wr_take, do_write;
	logic [7:0] wr_addr_q, next_wr_addr;
	logic aw_got, next_aw_got, w_got, next_w_got;
	logic [31:0] wdata_q, next_wdata;
	logic [3:0] wstrb_q, next_wstrb;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata, rd_mux;
	logic rd_hit, wr_hit;

	assign test_mode = test_reg;

	// ------------------------------------------------------------
	// Edge choice and write gating
	// ------------------------------------------------------------
	// Test mode hands the edge choice to the auto-stop pin
	assign eff_edge = test_reg ? asw_s : oedge_s;
	assign auto_stop = buf_en && !test_reg && asw_s;
	assign rrise = rclk_s && !rclk_q;
	assign load = rrise && ren_s && (!buf_en || !fifo.empty);
	// Any write attempt into a full buffer, dropped or overwriting
	assign over_ev = wen_s && buf_en && fifo.full;

	assign fifo.wr = wen_s && buf_en && !rst_s && !(auto_stop && fifo.full);
	assign fifo.wr_data = sample_in;
	// Both edges may coincide; the buffer takes the write and the pop in the same cycle
	assign fifo.pop = rrise && ren_s && buf_en && !rst_s;
	assign fifo.flush = flush || rst_s;
	assign fifo.depth_sel = bsize_s;

	always_comb begin
		next_rclk_q = rclk_s;
		next_out = sample_out_bits;
		next_strobe = data_ready_strobe;
		if (rst_s) begin
			next_out = '0;
			next_strobe = 1'b0;
		end else if (load) begin
			// Bypass shows the live sample instead of the buffer head
			next_out = buf_en ? fifo.rd_data : sample_in;
			next_strobe = eff_edge;
		end else if (!rclk_s) begin
			// Resting opposite the launch level gives every byte its own edge
			next_strobe = !eff_edge;
		end
		next_full_f = fifo.full && !fifo.flush;
		next_empty_f = fifo.empty || fifo.flush;
		next_test = tlev_s;
		next_pll = mult_s;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rclk_q <= 1'b0;
			sample_out_bits <= '0;
			data_ready_strobe <= 1'b0;
			buffer_full_flag <= 1'b0;
			buffer_empty_flag <= 1'b1;
			test_reg <= 1'b0;
			pll_factor <= '0;
		end else begin
			rclk_q <= next_rclk_q;
			sample_out_bits <= next_out;
			data_ready_strobe <= next_strobe;
			buffer_full_flag <= next_full_f;
			buffer_empty_flag <= next_empty_f;
			test_reg <= next_test;
			pll_factor <= next_pll;
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	assign irq_ev = {over_ev, next_empty_f && !buffer_empty_flag,
		next_full_f && !buffer_full_flag};

	always_comb begin
		next_irq_stat = irq_stat;
		next_irq_mask = irq_mask;
		if (do_write && wstrb_q[0] && wr_addr_q == acb_pkg::OFS_IRQ_STAT) begin
			next_irq_stat = irq_stat & ~wdata_q[acb_pkg::IRQ_W-1:0];
		end
		if (do_write && wstrb_q[0] && wr_addr_q == acb_pkg::OFS_IRQ_MASK) begin
			next_irq_mask = wdata_q[acb_pkg::IRQ_W-1:0];
		end
		// Set wins over a clear in the same cycle
		next_irq_stat = next_irq_stat | irq_ev;
		// One register late, so irq leaves straight from a flop
		next_irq = |(irq_stat & irq_mask);
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			irq_stat <= '0;
			irq_mask <= acb_pkg::IRQ_MASK_RST;
			irq <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			irq <= next_irq;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	assign do_write = aw_got && w_got && !s_axi_bvalid;
	assign wr_take = s_axi_awvalid && s_axi_awready;
	assign wr_hit = wr_addr_q == acb_pkg::OFS_CTRL || wr_addr_q == acb_pkg::OFS_STAT
		|| wr_addr_q == acb_pkg::OFS_IRQ_STAT || wr_addr_q == acb_pkg::OFS_IRQ_MASK;
	assign rd_hit = s_axi_araddr == acb_pkg::OFS_CTRL || s_axi_araddr == acb_pkg::OFS_STAT
		|| s_axi_araddr == acb_pkg::OFS_IRQ_STAT || s_axi_araddr == acb_pkg::OFS_IRQ_MASK;

	always_comb begin
		rd_mux = '0;
		case (s_axi_araddr)
			acb_pkg::OFS_CTRL: rd_mux[acb_pkg::CTRL_BUF_EN] = buf_en;
			acb_pkg::OFS_STAT: begin
				rd_mux[acb_pkg::STAT_FULL] = buffer_full_flag;
				rd_mux[acb_pkg::STAT_EMPTY] = buffer_empty_flag;
				rd_mux[acb_pkg::STAT_TEST] = test_reg;
				rd_mux[acb_pkg::STAT_WEN] = wen_s;
				rd_mux[acb_pkg::STAT_BUF_EN] = buf_en;
				rd_mux[acb_pkg::STAT_DEPTH +: 2] = bsize_s;
				rd_mux[acb_pkg::STAT_PLL +: 2] = pll_factor;
				rd_mux[acb_pkg::STAT_COUNT +: acb_pkg::CNT_W] = fifo.count;
			end
			acb_pkg::OFS_IRQ_STAT: rd_mux[acb_pkg::IRQ_W-1:0] = irq_stat;
			acb_pkg::OFS_IRQ_MASK: rd_mux[acb_pkg::IRQ_W-1:0] = irq_mask;
			default: rd_mux = '0;
		endcase
	end

	always_comb begin
		next_aw_got = aw_got;
		next_wr_addr = wr_addr_q;
		next_w_got = w_got;
		next_wdata = wdata_q;
		next_wstrb = wstrb_q;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_buf_en = buf_en;
		next_flush = 1'b0;
		if (wr_take) begin
			next_aw_got = 1'b1;
			next_wr_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_got = 1'b1;
			next_wdata = s_axi_wdata;
			next_wstrb = s_axi_wstrb;
		end
		if (do_write) begin
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wr_hit ? acb_pkg::RESP_OKAY : acb_pkg::RESP_SLVERR;
			if (wstrb_q[0] && wr_addr_q == acb_pkg::OFS_CTRL) begin
				next_buf_en = wdata_q[acb_pkg::CTRL_BUF_EN];
				next_flush = wdata_q[acb_pkg::CTRL_FLUSH];
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (rst_s) begin
			next_buf_en = acb_pkg::CTRL_BUF_EN_RST;
		end
		next_awready = !next_aw_got;
		next_wready = !next_w_got;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rdata = rd_mux;
			next_rresp = rd_hit ? acb_pkg::RESP_OKAY : acb_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			aw_got <= 1'b0;
			wr_addr_q <= '0;
			w_got <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= acb_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= acb_pkg::RESP_OKAY;
			buf_en <= acb_pkg::CTRL_BUF_EN_RST;
			flush <= 1'b0;
		end else begin
			aw_got <= next_aw_got;
			wr_addr_q <= next_wr_addr;
			w_got <= next_w_got;
			wdata_q <= next_wdata;
			wstrb_q <= next_wstrb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			buf_en <= next_buf_en;
			flush <= next_flush;
		end
	end
endmodule : acb_top

// ==== test/acb_top_props.sv ====
`timescale 1ns/1ps
module acb_top_props (
	input wire logic clock,
	input wire logic rstn,
	input wire logic write_enable,
	input wire logic write_enable_synced_out,
	input wire logic buffer_full_flag,
	input wire logic buffer_empty_flag,
	input wire logic [7:0] sample_out_bits,
	input wire logic data_ready_strobe,
	input wire logic test_mode,
	input wire logic test_level_sense,
	input wire logic auto_stop_write,
	input wire logic output_edge_select_or_test,
	input wire logic [1:0] pll_factor_select,
	input wire logic [1:0] pll_factor,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking dcb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// ------------------------------------------------------------
	// Pin relations
	// ------------------------------------------------------------
	a_wen_sync: assert property (write_enable_synced_out == $past(write_enable, 2))
		else $error("synced write enable lags wrongly");
	a_flag_excl: assert property (!(buffer_full_flag && buffer_empty_flag))
		else $error("full and empty together");
	a_strobe_level: assert property ($changed(sample_out_bits) |-> data_ready_strobe ==
		(test_mode ? auto_stop_write : output_edge_select_or_test))
		else $error("strobe level wrong at data change");
	// Strobe must swing back before the next byte so each byte gets its own edge
	a_strobe_swing: assert property ($changed(sample_out_bits) |=> ##[0:40] $changed(data_ready_strobe))
		else $error("strobe did not swing after data change");
	a_pll_copy: assert property ($stable(pll_factor_select) [*4] |-> pll_factor == pll_factor_select)
		else $error("pll factor not copied");
	a_test_copy: assert property ($stable(test_level_sense) [*4] |-> test_mode == test_level_sense)
		else $error("test mode not following sense");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	c_full: cover property ($rose(buffer_full_flag));
	c_byte: cover property ($changed(sample_out_bits));
	c_test: cover property (test_mode && $changed(sample_out_bits));
endmodule : acb_top_props
bind acb_top acb_top_props u_props (.clock, .rstn, .write_enable, .write_enable_synced_out,
	.buffer_full_flag, .buffer_empty_flag, .sample_out_bits, .data_ready_strobe, .test_mode,
	.test_level_sense, .auto_stop_write, .output_edge_select_or_test, .pll_factor_select,
	.pll_factor, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata);

// ==== test/acb_reader_model.sv ====
`timescale 1ns/1ps
module acb_reader_model (
	output logic read_clock,
	output logic read_enable
);
	initial begin
		read_clock = 1'b0;
		read_enable = 1'b0;
	end
	// Link clock stands still between reads, as a real reader stops it
	task automatic read_byte;
		read_enable <= 1'b1;
		#62.5 read_clock <= 1'b1;
		#62.5 read_clock <= 1'b0;
		read_enable <= 1'b0;
		#62.5;
	endtask : read_byte
endmodule : acb_reader_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	logic clock, rstn, reset_pin, write_enable, read_enable, read_clock, irq;
	logic output_edge_select_or_test, test_level_sense, auto_stop_write, test_mode;
	logic [7:0] sample_in, sample_out_bits, s_axi_awaddr, s_axi_araddr, first;
	logic [1:0] buffer_depth_select, pll_factor_select, pll_factor, s_axi_bresp, s_axi_rresp, rr;
	logic data_ready_strobe, buffer_full_flag, buffer_empty_flag, write_enable_synced_out;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	int failures, n_tests;
	acb_top uut (.clock, .rstn, .reset_pin, .sample_in, .write_enable, .read_enable, .read_clock,
		.output_edge_select_or_test, .test_level_sense, .auto_stop_write, .buffer_depth_select,
		.pll_factor_select, .sample_out_bits, .data_ready_strobe, .buffer_full_flag,
		.buffer_empty_flag, .write_enable_synced_out, .pll_factor, .test_mode, .irq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	acb_reader_model rdr (.read_clock, .read_enable);
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) sample_in <= sample_in + 8'h01;
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic hung;
		failures++;
		$display("BAD bus answer exp response got none");
		complete_run();
	endtask : hung
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (i == 64) hung();
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		int i;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (i == 64) hung();
	endtask : axi_rd
	// Enable held n cycles gives n stored bytes once synchronised;
	// the first lands at the third edge, two sync stages behind the pin
	task automatic burst(input int n);
		@(posedge clock);
		write_enable <= 1'b1;
		for (int c = 1; c <= n + 6; c++) begin
			@(posedge clock);
			if (c == 3) first = sample_in;
			if (c == n) write_enable <= 1'b0;
		end
	endtask : burst
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		{rstn, reset_pin, write_enable, test_level_sense, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, buffer_depth_select, pll_factor_select} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, sample_in} = '0;
		{output_edge_select_or_test, auto_stop_write, s_axi_wstrb} = 6'h3F;
		failures = 0;
		n_tests = 0;
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		repeat (2) @(posedge clock);
		chk("empty_rst", 32'h1, buffer_empty_flag);
		chk("full_rst", 32'h0, buffer_full_flag);
		axi_rd(acb_pkg::OFS_STAT);
		chk("stat_rst", 32'h12, rv);
		axi_rd(acb_pkg::OFS_IRQ_MASK);
		chk("mask_rst", 32'h0, rv);
		axi_rd(8'h10);
		chk("unmapped", acb_pkg::RESP_SLVERR, rr);
		axi_wr(8'h10, 32'h0);
		chk("wr_unmapped", acb_pkg::RESP_SLVERR, rr);
		$display("test reset done");
		burst(140);
		axi_rd(acb_pkg::OFS_STAT);
		chk("fill_count", 32'h80, rv[26:16]);
		chk("fill_full", 32'h1, buffer_full_flag);
		axi_wr(acb_pkg::OFS_IRQ_MASK, 32'h1);
		chk("wr_okay", acb_pkg::RESP_OKAY, rr);
		repeat (3) @(posedge clock);
		chk("irq_on", 32'h1, irq);
		axi_wr(acb_pkg::OFS_IRQ_STAT, 32'h7);
		repeat (3) @(posedge clock);
		chk("irq_off", 32'h0, irq);
		buffer_depth_select <= 2'h1;
		repeat (8) @(posedge clock);
		chk("full_256", 32'h0, buffer_full_flag);
		$display("test fill done");
		reset_pin <= 1'b1;
		repeat (6) @(posedge clock);
		reset_pin <= 1'b0;
		repeat (6) @(posedge clock);
		chk("pin_empty", 32'h1, buffer_empty_flag);
		axi_rd(acb_pkg::OFS_STAT);
		chk("pin_count", 32'h0, rv[26:16]);
		$display("test reset_pin done");
		for (int k = 0; k < 2; k++) begin
			output_edge_select_or_test <= (k == 0);
			burst(5);
			chk("rd_empty0", 32'h0, buffer_empty_flag);
			for (int j = 0; j < 6; j++) begin
				rdr.read_byte();
				chk("rd_byte", first + 8'(j < 5 ? j : 4), sample_out_bits);
			end
			chk("rd_empty1", 32'h1, buffer_empty_flag);
		end
		$display("test read done");
		{test_level_sense, auto_stop_write, output_edge_select_or_test} <= 3'h5;
		repeat (8) @(posedge clock);
		chk("test_mode", 32'h1, test_mode);
		burst(2);
		rdr.read_byte();
		rdr.read_byte();
		chk("test_empty", 32'h1, buffer_empty_flag);
		{test_level_sense, auto_stop_write} <= 2'h1;
		pll_factor_select <= 2'h2;
		repeat (8) @(posedge clock);
		chk("pll", 32'h2, pll_factor);
		$display("test mode done");
		burst(3);
		axi_wr(acb_pkg::OFS_CTRL, 32'h3);
		repeat (4) @(posedge clock);
		chk("flush", 32'h1, buffer_empty_flag);
		axi_wr(acb_pkg::OFS_CTRL, 32'h0);
		burst(4);
		axi_rd(acb_pkg::OFS_STAT);
		chk("off_count", 32'h0, rv[26:16]);
		axi_wr(acb_pkg::OFS_CTRL, 32'h1);
		$display("test control done");
		complete_run();
	end
endmodule : tb_top
